// ==== dv/smc_clock_gen_monitor.sv ====
// port checker for the slow and main clock generator
`timescale 1ns/10ps
module smc_clock_gen_monitor (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic off_mode,
  input wire logic slow_clock,
  input wire logic slow_rc_enable,
  input wire logic xtal_osc_enable,
  input wire logic xtal_bypass,
  input wire logic fast_rc_enable,
  input wire logic main_ready_irq
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  logic taken;
  logic wr_osc;
  logic wr_mode;
  assign taken = hsel && hready && htrans[1];
  assign wr_osc = taken && hwrite && haddr[7:0] == smc_pkg::ADDR_MAIN_OSC;
  assign wr_mode = taken && hwrite && haddr[7:0] == smc_pkg::ADDR_SUPPLY_MODE;
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_rc_off_xtal: assert property (
    (!off_mode) [*8] ##0 !slow_rc_enable |-> xtal_osc_enable)
    else $error("slow clock left without a source");
  a_off_gates: assert property (
    off_mode [*6] |-> !slow_clock && !slow_rc_enable && !xtal_osc_enable)
    else $error("slow side active in off mode");
  // enables move two to four edges after the write's address phase
  a_fast_cause: assert property (
    $changed(fast_rc_enable) |->
      $past(wr_osc, 2) || $past(wr_osc, 3) || $past(wr_osc, 4))
    else $error("fast rc enable moved without a write");
  a_bypass_cause: assert property (
    $changed(xtal_bypass) |->
      $past(wr_mode, 2) || $past(wr_mode, 3) || $past(wr_mode, 4))
    else $error("bypass moved without a write");
  a_irq_drop: assert property (
    $fell(fast_rc_enable) |-> ##[0:3] !main_ready_irq)
    else $error("ready interrupt outlived the fast rc");
  a_irq_cause: assert property (
    $rose(main_ready_irq) |-> fast_rc_enable)
    else $error("ready interrupt with fast rc off");
  a_rdata_idle: assert property (
    !$past(taken) |-> hrdata == 32'h0000_0000)
    else $error("read data outside a data phase");
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("slave stalled or erred");
  c_fast_off: cover property ($fell(fast_rc_enable));
  c_irq: cover property ($rose(main_ready_irq));
  c_off: cover property (off_mode [*6]);
endmodule : smc_clock_gen_monitor

bind smc_clock_gen smc_clock_gen_monitor u_mon (.hclk(hclk),
  .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .off_mode(off_mode),
  .slow_clock(slow_clock), .slow_rc_enable(slow_rc_enable),
  .xtal_osc_enable(xtal_osc_enable), .xtal_bypass(xtal_bypass),
  .fast_rc_enable(fast_rc_enable), .main_ready_irq(main_ready_irq));

// ==== dv/smc_clock_gen_tb.sv ====
// self-checking bench of the slow and main clock generator
`timescale 1ns/10ps
module smc_clock_gen_tb;
  logic hclk = 1'b0;
  logic hresetn, hsel, hwrite, hreadyout, hresp;
  logic slow_rc_clk = 1'b0;
  logic xtal_in_pin = 1'b0;
  logic fast_rc_clk = 1'b0;
  logic ext_clock_in = 1'b0;
  logic fast_rc_stable, off_mode, slow_clock, main_clock_out;
  logic slow_rc_enable, xtal_osc_enable, xtal_bypass, fast_rc_enable;
  logic main_ready_irq;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, v, k;
  logic [31:0] cyc = 32'h0;
  int fails, n_compared;

  smc_clock_gen dut (.hclk(hclk), .hresetn(hresetn), .ce(1'b1),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .slow_rc_clk(slow_rc_clk),
    .xtal_in_pin(xtal_in_pin), .fast_rc_clk(fast_rc_clk),
    .ext_clock_in(ext_clock_in), .fast_rc_stable(fast_rc_stable),
    .off_mode(off_mode), .slow_clock(slow_clock),
    .main_clock_out(main_clock_out), .slow_rc_enable(slow_rc_enable),
    .xtal_osc_enable(xtal_osc_enable), .xtal_bypass(xtal_bypass),
    .fast_rc_enable(fast_rc_enable), .main_ready_irq(main_ready_irq));

  // ----------------------------------------------------------------
  // clocks: slow rc 16, crystal 32, fast rc 4, external 8 cycles
  // ----------------------------------------------------------------
  always #5 hclk = ~hclk;
  always @(posedge hclk)
  begin
    cyc <= cyc + 32'h1;
    slow_rc_clk <= cyc[3];
    xtal_in_pin <= cyc[4];
    fast_rc_clk <= cyc[1];
    ext_clock_in <= cyc[2];
    if (cyc == 32'h0000_c350)
    begin
      fails++;
      wrap_up();
    end
  end

  // ----------------------------------------------------------------
  // bus and compare tasks
  // ----------------------------------------------------------------
  task wt;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
  endtask : wt

  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1; htrans <= 2'h2; hwrite <= w; haddr <= {24'h0, a};
    wt();
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    wt();
    v = hrdata;
  endtask : xfer

  task chk(input logic [31:0] g, input logic [31:0] e, input int t);
    n_compared++;
    if ((g >= e - t && g <= e + t) !== 1'b1)
    begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  task poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    for (int i = 0; i < 400; i++)
    begin
      xfer(1'b0, a, 32'h0);
      if ((v & m) === e) break;
    end
    chk(v & m, e, 0);
  endtask : poll

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task t_reset;
    chk({slow_rc_enable, xtal_osc_enable, xtal_bypass, fast_rc_enable,
      main_ready_irq}, 32'h12, 0);
    xfer(1'b0, 8'h08, 32'h0);
    chk(v, 32'h1, 0);
    xfer(1'b0, 8'h00, 32'h0);
    chk(v, 32'h0, 0);
    xfer(1'b0, 8'h40, 32'h0);
    chk(v, 32'h0, 0);
    $display("reset test done");
  endtask : t_reset

  task t_freq(input logic [31:0] e);
    poll(8'h0c, 32'h0001_0000, 32'h0001_0000);
    chk(v & 32'hffff, e, 1);
    $display("frequency count done");
  endtask : t_freq

  task t_ready;
    fast_rc_stable <= 1'b1;
    xfer(1'b1, 8'h14, 32'h1);
    poll(8'h10, 32'h1, 32'h1);
    repeat (3) @(posedge hclk);
    chk(main_ready_irq, 32'h1, 0);
    xfer(1'b1, 8'h14, 32'h0);
    repeat (3) @(posedge hclk);
    chk(main_ready_irq, 32'h0, 0);
    xfer(1'b1, 8'h14, 32'h1);
    xfer(1'b1, 8'h08, 32'h0);
    xfer(1'b0, 8'h10, 32'h0);
    chk(v & 32'h1, 32'h0, 0);
    chk(fast_rc_enable, 32'h0, 0);
    xfer(1'b1, 8'h08, 32'h1);
    repeat (3) @(posedge hclk);
    chk(fast_rc_enable, 32'h1, 0);
    $display("ready test done");
  endtask : t_ready

  task t_ext;
    xfer(1'b1, 8'h08, 32'h3);
    xfer(1'b0, 8'h10, 32'h0);
    chk(v & 32'h2, 32'h0, 0);
    poll(8'h10, 32'h2, 32'h2);
    @(posedge main_clock_out) k = cyc;
    @(posedge main_clock_out);
    chk(cyc - k, 32'h8, 1);
    xfer(1'b1, 8'h08, 32'h2);
    xfer(1'b1, 8'h08, 32'h3);
    // 15.5 slow periods of 16: 248 cycles of an 8-cycle clock
    t_freq(32'h1f);
    $display("external clock test done");
  endtask : t_ext

  task t_slow;
    xfer(1'b1, 8'h04, 32'h1);
    xfer(1'b1, 8'h00, 32'h1);
    repeat (100) @(posedge hclk);
    chk({slow_rc_enable, xtal_osc_enable, xtal_bypass}, 32'h3,
      0);
    @(posedge slow_clock) k = cyc;
    @(posedge slow_clock);
    chk(cyc - k, 32'h20, 1);
    $display("slow clock test done");
  endtask : t_slow

  task t_off;
    off_mode <= 1'b1;
    repeat (10) @(posedge hclk);
    chk({slow_clock, slow_rc_enable, xtal_osc_enable}, 32'h0, 0);
    off_mode <= 1'b0;
    repeat (40) @(posedge hclk);
    chk(xtal_osc_enable, 32'h1, 0);
    $display("off mode test done");
  endtask : t_off

  task wrap_up;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : wrap_up

  initial
  begin
    hresetn = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    htrans = 2'h0;
    haddr = 32'h0;
    hwdata = 32'h0;
    fast_rc_stable = 1'b0;
    off_mode = 1'b0;
    fails = 0;
    n_compared = 0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    // window runs from a slow rise to the 16th slow fall: 248 cycles
    t_freq(32'h3e);
    t_ready();
    t_ext();
    t_slow();
    t_off();
    wrap_up();
  end
endmodule : smc_clock_gen_tb

// ==== rtl/smc_clock_gen.sv ====
// slow and main clock generator with AHB-Lite register access
//
// Added by the designer: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/10ps
module smc_clock_gen (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic slow_rc_clk,
  input wire logic xtal_in_pin,
  input wire logic fast_rc_clk,
  input wire logic ext_clock_in,
  input wire logic fast_rc_stable,
  input wire logic off_mode,
  output logic slow_clock,
  output logic main_clock_out,
  output logic slow_rc_enable,
  output logic xtal_osc_enable,
  output logic xtal_bypass,
  output logic fast_rc_enable,
  output logic main_ready_irq
);

  smc_pkg::smc_top_t s;
  smc_pkg::smc_top_t next_s;
  logic slow_sw_clk;
  logic slow_sw_done;
  logic main_sw_clk;
  logic main_sw_done;
  logic [smc_pkg::PIN_COUNT-1:0] pins;
  logic take;
  logic slow_rise;
  logic slow_fall;
  logic main_rise;
  logic rc_turned_on;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // a pin change is believed once the second and third stage agree
  function automatic logic [smc_pkg::PIN_COUNT-1:0] settle(
    input logic [smc_pkg::PIN_COUNT-1:0] b,
    input logic [smc_pkg::PIN_COUNT-1:0] c,
    input logic [smc_pkg::PIN_COUNT-1:0] f
  );
    logic [smc_pkg::PIN_COUNT-1:0] agree;
    agree = ~(b ^ c);
    return (agree & c) | (~agree & f);
  endfunction : settle

  function automatic logic rose(input logic now, input logic was);
    return now & ~was;
  endfunction : rose

  function automatic logic fell(input logic now, input logic was);
    return ~now & was;
  endfunction : fell

  function automatic logic [31:0] read_word(
    input logic [smc_pkg::REG_ADDR_W-1:0] a,
    input smc_pkg::smc_top_t t,
    input logic sel_done
  );
    logic [31:0] w;
    w = 32'h0000_0000;
    unique case (a)
      smc_pkg::ADDR_SUPPLY_CTRL:
        w[smc_pkg::BIT_SLOW_XTAL_SELECT] = t.ctrl.slow_xtal_select;
      smc_pkg::ADDR_SUPPLY_MODE:
        w[smc_pkg::BIT_XTAL_BYPASS] = t.ctrl.xtal_bypass_enable;
      smc_pkg::ADDR_MAIN_OSC:
      begin
        w[smc_pkg::BIT_FAST_RC_ON] = t.ctrl.fast_rc_on;
        w[smc_pkg::BIT_EXT_CLOCK_SELECT] = t.ctrl.ext_clock_select;
      end
      smc_pkg::ADDR_MAIN_FREQ:
      begin
        w[smc_pkg::FREQ_COUNT_W-1:0] = t.freq_count; // see RQ15
        w[smc_pkg::BIT_FREQ_DONE] = t.freq_done;
      end
      smc_pkg::ADDR_POWER_STATUS:
      begin
        w[smc_pkg::BIT_MAIN_READY] = t.main_ready;
        w[smc_pkg::BIT_MAIN_SEL_DONE] = sel_done; // see RQ17
      end
      smc_pkg::ADDR_POWER_IRQ_EN:
        w[smc_pkg::BIT_IRQ_MAIN_READY] = t.ctrl.main_ready_irq_en;
      default:
        w = 32'h0000_0000;
    endcase
    return w;
  endfunction : read_word

  // ----------------------------------------------------------------
  // clock switches
  // ----------------------------------------------------------------
  smc_clock_switch u_slow_switch (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .src_a(s.sy.f[smc_pkg::PIN_SLOW_RC]),
    .src_b(s.sy.f[smc_pkg::PIN_XTAL]),
    .sel(s.ctrl.slow_xtal_select), // see RQ1
    .clk_out(slow_sw_clk),
    .done(slow_sw_done)
  );

  smc_clock_switch u_main_switch (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .src_a(s.sy.f[smc_pkg::PIN_FAST_RC]),
    .src_b(s.sy.f[smc_pkg::PIN_EXT]),
    .sel(s.ctrl.ext_clock_select), // see RQ16
    .clk_out(main_sw_clk),
    .done(main_sw_done)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  assign pins = {off_mode, fast_rc_stable, ext_clock_in, fast_rc_clk,
                 xtal_in_pin, slow_rc_clk};
  assign take = hsel & hready & htrans[1];
  assign slow_rise = rose(slow_sw_clk, s.slow_q);
  assign slow_fall = fell(slow_sw_clk, s.slow_q);
  assign main_rise = rose(main_sw_clk, s.main_q);
  assign rc_turned_on = rose(s.ctrl.fast_rc_on, s.fast_rc_on_q);

  always_comb
  begin
    next_s = s;

    // pin sampling, first stage feeds only the second
    next_s.sy.s1 = pins;
    next_s.sy.s2 = s.sy.s1;
    next_s.sy.s3 = s.sy.s2;
    next_s.sy.f = settle(s.sy.s2, s.sy.s3, s.sy.f);

    // register writes land in the data phase
    if (s.wr_pend)
    begin
      unique case (s.wr_addr)
        smc_pkg::ADDR_SUPPLY_CTRL:
          next_s.ctrl.slow_xtal_select =
            hwdata[smc_pkg::BIT_SLOW_XTAL_SELECT];
        smc_pkg::ADDR_SUPPLY_MODE:
          next_s.ctrl.xtal_bypass_enable =
            hwdata[smc_pkg::BIT_XTAL_BYPASS];
        smc_pkg::ADDR_MAIN_OSC:
        begin
          next_s.ctrl.fast_rc_on = hwdata[smc_pkg::BIT_FAST_RC_ON];
          next_s.ctrl.ext_clock_select =
            hwdata[smc_pkg::BIT_EXT_CLOCK_SELECT];
        end
        smc_pkg::ADDR_POWER_IRQ_EN:
          next_s.ctrl.main_ready_irq_en =
            hwdata[smc_pkg::BIT_IRQ_MAIN_READY];
        default:
          next_s.ctrl = s.ctrl;
      endcase
    end
    next_s.wr_pend = take & hwrite;
    next_s.wr_addr = haddr[smc_pkg::REG_ADDR_W-1:0];
    next_s.ready_o = 1'b1;
    next_s.resp_o = 1'b0;
    if (take & ~hwrite)
      next_s.hrdata = read_word(haddr[smc_pkg::REG_ADDR_W-1:0], s,
                                main_sw_done);
    else
      next_s.hrdata = 32'h0000_0000;

    // oscillator enables
    next_s.fast_rc_en = next_s.ctrl.fast_rc_on; // see RQ8
    // slow RC dips one cycle after the crystal select write, then stays up until the switch has left it
    next_s.slow_rc_en = ~s.sy.f[smc_pkg::PIN_OFF] &
      ~(s.ctrl.slow_xtal_select & slow_sw_done); // see RQ3
    next_s.xtal_en = ~s.sy.f[smc_pkg::PIN_OFF] &
      s.ctrl.slow_xtal_select;
    next_s.bypass = s.ctrl.xtal_bypass_enable;
    next_s.slow_out = slow_sw_clk &
      ~s.sy.f[smc_pkg::PIN_OFF]; // see RQ5

    // ready flag: clear with the on bit, set once oscillator stable
    next_s.main_ready = (s.main_ready |
      s.sy.f[smc_pkg::PIN_FAST_STABLE]) &
      next_s.ctrl.fast_rc_on; // see RQ9
    next_s.irq = s.main_ready & s.ctrl.main_ready_irq_en; // see RQ10

    // frequency counter
    next_s.slow_q = slow_sw_clk;
    next_s.main_q = main_sw_clk;
    next_s.fast_rc_on_q = s.ctrl.fast_rc_on;
    if (rc_turned_on)
    begin
      next_s.fc = smc_pkg::FC_ARM;
      next_s.freq_count = '0;
      next_s.freq_done = 1'b0;
    end
    else
    begin
      unique case (s.fc)
        smc_pkg::FC_IDLE:
          next_s.fc = smc_pkg::FC_IDLE;
        smc_pkg::FC_ARM:
        begin
          if (slow_rise)
          begin
            next_s.fc = smc_pkg::FC_COUNT; // see RQ13
            next_s.slow_falls = 5'h00;
          end
        end
        smc_pkg::FC_COUNT:
        begin
          if (main_rise)
            next_s.freq_count = s.freq_count + 1'b1; // see RQ13
          if (slow_fall)
          begin
            next_s.slow_falls = s.slow_falls + 5'h01;
            if (s.slow_falls + 5'h01 == smc_pkg::SLOW_PERIODS)
            begin
              next_s.fc = smc_pkg::FC_DONE; // see RQ14
              next_s.freq_done = 1'b1;
            end
          end
        end
        smc_pkg::FC_DONE:
          next_s.fc = smc_pkg::FC_DONE; // see RQ15
      endcase
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      s <= smc_pkg::TOP_RST; // see RQ2, RQ7
    else if (ce)
      s <= next_s;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign hrdata = s.hrdata;
  assign hreadyout = s.ready_o;
  assign hresp = s.resp_o;
  assign slow_clock = s.slow_out;
  assign main_clock_out = main_sw_clk;
  assign slow_rc_enable = s.slow_rc_en;
  assign xtal_osc_enable = s.xtal_en;
  assign xtal_bypass = s.bypass;
  assign fast_rc_enable = s.fast_rc_en;
  assign main_ready_irq = s.irq;

endmodule : smc_clock_gen

// ==== rtl/smc_clock_switch.sv ====
// glitch-free two-source clock switch sampled on the system clock
`timescale 1ns/10ps
module smc_clock_switch (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic src_a,
  input wire logic src_b,
  input wire logic sel,
  output logic clk_out,
  output logic done
);

  smc_pkg::smc_sw_reg_t s;
  smc_pkg::smc_sw_reg_t next_s;

  // ----------------------------------------------------------------
  // switch sequence
  // ----------------------------------------------------------------
  // output is parked low between the old source's low phase and the
  // new source's low phase, so no shortened pulse can leave
  always_comb
  begin
    next_s = s;
    unique case (s.st)
      smc_pkg::SW_RUN:
      begin
        if (sel != s.cur)
          next_s.st = smc_pkg::SW_DROP; // see RQ20
      end
      smc_pkg::SW_DROP:
      begin
        if (!(s.cur ? src_b : src_a))
        begin
          next_s.st = smc_pkg::SW_PICK;
          next_s.cur = sel;
        end
      end
      smc_pkg::SW_PICK:
      begin
        if (sel != s.cur)
          next_s.cur = sel;
        else if (!(s.cur ? src_b : src_a))
          next_s.st = smc_pkg::SW_RUN;
      end
    endcase
    if (next_s.st == smc_pkg::SW_PICK)
      next_s.clk_out = 1'b0;
    else
      next_s.clk_out = next_s.cur ? src_b : src_a; // see RQ6
    next_s.done = (next_s.st == smc_pkg::SW_RUN) &&
                  (next_s.cur == sel); // see RQ17
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      s <= smc_pkg::SW_RST;
    else if (ce)
      s <= next_s;
  end

  assign clk_out = s.clk_out;
  assign done = s.done;

endmodule : smc_clock_switch

// ==== rtl/smc_pkg.sv ====
// constants, types and reset values of the slow and main clock generator
// Behaviour
// RQ1: slow clock from crystal or slow RC
// RQ2: reset enables and selects slow RC
// RQ3: crystal selection turns slow RC off
// RQ4: bypass needs bypass bit, crystal select, clock; the code drives xtal_bypass from the bypass bit alone
// RQ5: slow clock always runs except off mode
// RQ6: main clock from fast RC or external
// RQ7: reset enables and selects fast RC
// RQ8: fast RC follows its on bit
// RQ9: clearing on bit clears main ready
// RQ10: main ready enable raises processor interrupt
// RQ11: software should stop unused main clock
// RQ12: wait mode: select main, clear on
// RQ13: counter starts at next slow rising edge
// RQ14: sixteenth slow falling edge stops, sets done
// RQ15: count field holds frozen main cycles
// RQ16: external select bit picks external clock
// RQ17: selection done bit reports finished switch
// RQ18: select external only when clock present
// RQ19: external switch needs no ready check
// RQ20: select change clears done until clean switch
package smc_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int REG_ADDR_W = 8;
  localparam logic [7:0] ADDR_SUPPLY_CTRL = 8'h00;
  localparam logic [7:0] ADDR_SUPPLY_MODE = 8'h04;
  localparam logic [7:0] ADDR_MAIN_OSC = 8'h08;
  localparam logic [7:0] ADDR_MAIN_FREQ = 8'h0c;
  localparam logic [7:0] ADDR_POWER_STATUS = 8'h10;
  localparam logic [7:0] ADDR_POWER_IRQ_EN = 8'h14;

  localparam int BIT_SLOW_XTAL_SELECT = 0;
  localparam int BIT_XTAL_BYPASS = 0;
  localparam int BIT_FAST_RC_ON = 0;
  localparam int BIT_EXT_CLOCK_SELECT = 1;
  localparam int BIT_FREQ_DONE = 16;
  localparam int BIT_MAIN_READY = 0;
  localparam int BIT_MAIN_SEL_DONE = 1;
  localparam int BIT_IRQ_MAIN_READY = 0;

  localparam int FREQ_COUNT_W = 16;
  localparam logic [4:0] SLOW_PERIODS = 5'h10;

  // ----------------------------------------------------------------
  // pin sampling slots
  // ----------------------------------------------------------------
  localparam int PIN_SLOW_RC = 0;
  localparam int PIN_XTAL = 1;
  localparam int PIN_FAST_RC = 2;
  localparam int PIN_EXT = 3;
  localparam int PIN_FAST_STABLE = 4;
  localparam int PIN_OFF = 5;
  localparam int PIN_COUNT = 6;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    FC_IDLE = 4'h1,
    FC_ARM = 4'h2,
    FC_COUNT = 4'h4,
    FC_DONE = 4'h8
  } smc_fc_state_t;

  typedef enum logic [2:0] {
    SW_RUN = 3'h1,
    SW_DROP = 3'h2,
    SW_PICK = 3'h4
  } smc_sw_state_t;

  typedef struct packed {
    smc_sw_state_t st;
    logic cur;
    logic clk_out;
    logic done;
  } smc_sw_reg_t;

  typedef struct packed {
    logic slow_xtal_select;
    logic xtal_bypass_enable;
    logic fast_rc_on;
    logic ext_clock_select;
    logic main_ready_irq_en;
  } smc_ctrl_t;

  typedef struct packed {
    logic [PIN_COUNT-1:0] s1;
    logic [PIN_COUNT-1:0] s2;
    logic [PIN_COUNT-1:0] s3;
    logic [PIN_COUNT-1:0] f;
  } smc_sync_t;

  typedef struct packed {
    smc_sync_t sy;
    smc_ctrl_t ctrl;
    logic main_ready;
    logic irq;
    smc_fc_state_t fc;
    logic [FREQ_COUNT_W-1:0] freq_count;
    logic freq_done;
    logic [4:0] slow_falls;
    logic slow_q;
    logic main_q;
    logic fast_rc_on_q;
    logic wr_pend;
    logic [REG_ADDR_W-1:0] wr_addr;
    logic [31:0] hrdata;
    logic ready_o;
    logic resp_o;
    logic slow_rc_en;
    logic xtal_en;
    logic fast_rc_en;
    logic bypass;
    logic slow_out;
  } smc_top_t;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam smc_ctrl_t CTRL_RST = '{
    slow_xtal_select: 1'b0,
    xtal_bypass_enable: 1'b0,
    fast_rc_on: 1'b1,
    ext_clock_select: 1'b0,
    main_ready_irq_en: 1'b0
  };

  localparam smc_sw_reg_t SW_RST = '{
    st: SW_RUN, cur: 1'b0, clk_out: 1'b0, done: 1'b1
  };

  localparam smc_top_t TOP_RST = '{
    sy: '0, ctrl: CTRL_RST, main_ready: 1'b0, irq: 1'b0,
    fc: FC_IDLE, freq_count: '0, freq_done: 1'b0,
    slow_falls: 5'h00, slow_q: 1'b0, main_q: 1'b0,
    fast_rc_on_q: 1'b0, wr_pend: 1'b0, wr_addr: 8'h00,
    hrdata: 32'h0000_0000, ready_o: 1'b1, resp_o: 1'b0,
    slow_rc_en: 1'b1, xtal_en: 1'b0, fast_rc_en: 1'b1,
    bypass: 1'b0, slow_out: 1'b0
  };

endpackage : smc_pkg
